// ---- rtl/buck_gate_sync_sequencer.sv ----
// gate sequencer of a synchronous buck controller
// assumes 10 MHz CLK_IN; pins and sync input asynchronous to it
`timescale 1ns/10ps
module buck_gate_sync_sequencer (
    input  wire logic                              CLK_IN,
    input  wire logic                              SYS_RST_IN,
    input  wire logic                              SYNC_IN_IN,
    input  wire logic                              ENABLE_IN,
    input  wire logic                              SW_HIGH_IN,
    input  wire logic                              LS_GATE_HIGH_IN,
    input  wire logic                              ZERO_CURRENT_IN,
    input  wire logic                              ERROR_LOW_IN,
    input  wire logic                              PWM_END_IN,
    input  wire logic                              RAMP_OK_IN,
    input  wire logic                              CURRENT_LIMIT_IN,
    input  wire logic                              OUTPUT_DROOP_IN,
    input  wire logic                              INPUT_LOW_THRESHOLD_IN,
    input  wire logic                              VIN_HIGH_IN,
    input  wire logic                              FOLDBACK_IN,
    input  wire logic                              WB_CYC_IN,
    input  wire logic                              WB_STB_IN,
    input  wire logic                              WB_WE_IN,
    input  wire logic [buck_seq_pkg::WB_ADR_W-1:0] WB_ADR_IN,
    input  wire logic [31:0]                       WB_DAT_IN,
    input  wire logic [3:0]                        WB_SEL_IN,
    output logic      [31:0]                       WB_DAT_OUT,
    output logic                                   WB_ACK_OUT,
    output logic                                   HIGH_SIDE_GATE_OUT,
    output logic                                   LOW_SIDE_GATE_OUT,
    output logic                                   SYNC_OUT_OUT,
    output logic                                   SOFT_START_RELEASE_OUT,
    output logic                                   SINK_ENABLE_OUT,
    output logic                                   HYSTERETIC_MODE_OUT,
    output logic                                   LOW_IQ_OUT
);
    import buck_seq_pkg::*;

    // =========================================================
    // input conditioning
    comp_bus_if comp ();

    comp_filter u_filter (
        .clk_in (CLK_IN),
        .rst_in (SYS_RST_IN),
        .raw_in ({FOLDBACK_IN, VIN_HIGH_IN, INPUT_LOW_THRESHOLD_IN, OUTPUT_DROOP_IN,
                  CURRENT_LIMIT_IN, RAMP_OK_IN, PWM_END_IN, ERROR_LOW_IN,
                  ZERO_CURRENT_IN, LS_GATE_HIGH_IN, SW_HIGH_IN, ENABLE_IN}),
        .bus    (comp.source)
    );

    wire enable    = comp.level[C_ENABLE];
    wire sw_high   = comp.level[C_SW_HIGH];
    wire lsg_high  = comp.level[C_LSG_HIGH];
    wire zero_cur  = comp.level[C_ZERO_CUR];
    wire err_low   = comp.level[C_ERR_LOW];
    wire pwm_end   = comp.level[C_PWM_END];
    wire ramp_ok   = comp.level[C_RAMP_OK];
    wire cur_limit = comp.level[C_CUR_LIMIT];
    wire out_droop = comp.level[C_OUT_DROOP];
    wire input_low_threshold   = comp.level[C_INPUT_LOW_THRESHOLD];
    wire vin_high  = comp.level[C_VIN_HIGH];
    wire foldback  = comp.level[C_FOLDBACK];

    // sync input: two flops, then edge detect
    logic sync_meta;
    logic sync_lvl;
    logic sync_prev;

    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            sync_meta <= 1'b0;
            sync_lvl  <= 1'b0;
            sync_prev <= 1'b0;
        end else begin
            sync_meta <= SYNC_IN_IN;
            sync_lvl  <= sync_meta;
            sync_prev <= sync_lvl;
        end
    end

    wire sync_rise = sync_lvl & ~sync_prev;

    // =========================================================
    // registers and state
    seq_state_type state;
    seq_state_type next_state;
    logic [7:0] ctrl;
    logic [4:0] idle_cnt;
    logic       ext_sync;
    logic [4:0] phase;
    logic [3:0] pulse_num;
    logic [1:0] burst_num;
    logic [4:0] reassert_cnt;
    logic [3:0] on_cnt;
    logic       hs_on;
    logic       zc_off;
    logic [1:0] force_cnt;
    logic       forcing;
    logic       so_en;

    wire in_run    = (state == ST_RUN);
    wire in_burst  = (state == ST_BURST);
    wire in_skip   = (state == ST_SKIP);
    wire in_boot   = (state == ST_BOOT);
    wire in_reasrt = (state == ST_REASSERT);
    wire switching = in_run | in_burst;
    wire sync_loss = ext_sync & (idle_cnt == SYNC_LOSS_CYC);
    wire boot_last = (phase == BOOT_PERIOD_CYC - 5'h01) &
                     (pulse_num == BOOT_PULSES - 4'h1);
    wire de_mode   = ~sync_lvl & ~ext_sync;
    wire skip_en   = ctrl[CTRL_SKIP_EN];
    wire [3:0] max_on = ctrl[CTRL_MAXON_LO +: 4];

    // =========================================================
    // oscillators
    logic osc_tick;
    logic osc_sq;
    logic burst_tick;
    logic fix_sq;

    osc_divider u_osc (
        .clk_in     (CLK_IN),
        .rst_in     (SYS_RST_IN),
        .run_in     (enable & ~in_skip),
        .period_in  (OSC_PERIOD_CYC),
        .tick_out   (osc_tick),
        .square_out (osc_sq)
    );

    osc_divider u_burst (
        .clk_in     (CLK_IN),
        .rst_in     (SYS_RST_IN),
        .run_in     (in_burst),
        .period_in  (BURST_PERIOD_CYC),
        .tick_out   (burst_tick),
        .square_out ()
    );

    osc_divider u_fixed (
        .clk_in     (CLK_IN),
        .rst_in     (SYS_RST_IN),
        .run_in     (enable),
        .period_in  (OSC_PERIOD_CYC),
        .tick_out   (),
        .square_out (fix_sq)
    );

    // =========================================================
    // sequencing
    always_comb begin
        next_state = state;
        case (state)
            ST_OFF: begin
                if (enable) next_state = ST_BOOT;
            end
            ST_BOOT: begin
                if (boot_last) next_state = ST_RUN;
            end
            ST_RUN: begin
                if (sync_loss) begin
                    next_state = ST_REASSERT;
                end else if (skip_en && err_low) begin
                    next_state = ST_SKIP;
                end
            end
            ST_REASSERT: begin
                if (reassert_cnt == 5'h01) next_state = ST_RUN;
            end
            ST_SKIP: begin
                if (!err_low) next_state = ST_BURST;
            end
            ST_BURST: begin
                if (err_low && skip_en) begin
                    next_state = ST_SKIP;
                end else if (burst_tick && burst_num == BURST_PULSES - 2'h1) begin
                    next_state = ST_RUN;
                end
            end
            default: next_state = ST_OFF;
        endcase
        if (!enable) next_state = ST_OFF;
    end

    // new high pulse: sync rise, oscillator tick, or burst tick
    wire cycle_start = (in_run & (sync_rise | (~ext_sync & osc_tick))) |
                       (in_burst & burst_tick);
    wire vin_mid     = ~input_low_threshold & ~vin_high;
    wire zero_ok     = de_mode & vin_mid & in_run;

    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            state        <= ST_OFF;
            phase        <= 5'h00;
            pulse_num    <= 4'h0;
            burst_num    <= 2'h0;
            reassert_cnt <= 5'h00;
        end else begin
            state <= next_state;
            if (!in_boot) begin
                phase     <= 5'h00;
                pulse_num <= 4'h0;
            end else if (phase == BOOT_PERIOD_CYC - 5'h01) begin
                phase     <= 5'h00;
                pulse_num <= pulse_num + 4'h1;
            end else begin
                phase <= phase + 5'h01;
            end
            if (!in_burst) begin
                burst_num <= 2'h0;
            end else if (burst_tick) begin
                burst_num <= burst_num + 2'h1;
            end
            if (in_run && sync_loss) begin
                reassert_cnt <= sync_lvl ? REASSERT_HIGH_CYC : REASSERT_LOW_CYC;
            end else if (reassert_cnt != 5'h00) begin
                reassert_cnt <= reassert_cnt - 5'h01;
            end
        end
    end

    // external sync presence
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            idle_cnt <= 5'h00;
            ext_sync <= 1'b0;
        end else begin
            if (sync_rise) begin
                idle_cnt <= 5'h00;
            end else if (idle_cnt != SYNC_LOSS_CYC) begin
                idle_cnt <= idle_cnt + 5'h01;
            end
            if (sync_rise && enable) begin
                ext_sync <= 1'b1;
            end else if (sync_loss || !enable) begin
                ext_sync <= 1'b0;
            end
        end
    end

    // high-side on-time and zero-current latch
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            hs_on  <= 1'b0;
            on_cnt <= 4'h0;
            zc_off <= 1'b0;
        end else begin
            if (!switching) begin
                hs_on <= 1'b0;
            end else if (cycle_start && !hs_on) begin
                hs_on  <= ~(zero_ok & pwm_end);
                on_cnt <= 4'h1;
            end else if (hs_on && (pwm_end || on_cnt >= max_on)) begin
                hs_on <= 1'b0;
            end else if (hs_on) begin
                on_cnt <= on_cnt + 4'h1;
            end
            if (cycle_start || !de_mode) begin
                zc_off <= 1'b0;
            end else if (zero_cur && !hs_on) begin
                zc_off <= 1'b1;
            end
        end
    end

    // forced bootstrap recharge after a sync rise
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            force_cnt <= 2'h0;
            forcing   <= 1'b0;
        end else begin
            if (sync_rise) begin
                force_cnt <= FORCE_DELAY_CYC;
            end else if (force_cnt != 2'h0) begin
                force_cnt <= force_cnt - 2'h1;
            end
            if (!sync_lvl || !switching) begin
                forcing <= 1'b0;
            end else if (force_cnt == 2'h1) begin
                forcing <= sw_high & ctrl[CTRL_FORCE_EN];
            end
        end
    end

    // =========================================================
    // gate drive
    wire boot_pulse = in_boot & (phase < BOOT_PULSE_CYC);
    wire ls_normal  = (switching | in_skip) & ~hs_on & ~zc_off;
    wire ls_want    = boot_pulse | in_reasrt | ls_normal;
    wire next_ls    = forcing | (ls_want & ~sw_high);
    wire next_hs    = switching & hs_on & ~forcing & ~next_ls &
                      ~LOW_SIDE_GATE_OUT & ~lsg_high;

    // =========================================================
    // sync output and outputs
    wire next_sync_out = (~so_en | in_skip | ~enable) ? 1'b0 :
                         (cur_limit & out_droop) ? fix_sq :
                         ext_sync ? sync_lvl :
                         osc_sq;
    wire next_sink     = sync_lvl | ext_sync | input_low_threshold | foldback;

    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            so_en                  <= 1'b0;
            HIGH_SIDE_GATE_OUT     <= 1'b0;
            LOW_SIDE_GATE_OUT      <= 1'b0;
            SYNC_OUT_OUT           <= 1'b0;
            SOFT_START_RELEASE_OUT <= 1'b0;
            SINK_ENABLE_OUT        <= 1'b0;
            HYSTERETIC_MODE_OUT    <= 1'b0;
            LOW_IQ_OUT             <= 1'b0;
        end else begin
            if (state == ST_OFF || in_boot) begin
                so_en <= 1'b0;
            end else if (ramp_ok) begin
                so_en <= 1'b1;
            end
            HIGH_SIDE_GATE_OUT     <= next_hs;
            LOW_SIDE_GATE_OUT      <= next_ls;
            SYNC_OUT_OUT           <= next_sync_out;
            SOFT_START_RELEASE_OUT <= enable & (state != ST_OFF) & ~in_boot;
            SINK_ENABLE_OUT        <= next_sink;
            HYSTERETIC_MODE_OUT    <= de_mode & in_skip;
            LOW_IQ_OUT             <= in_skip;
        end
    end

    // =========================================================
    // wishbone slave
    wire        wb_req  = WB_CYC_IN & WB_STB_IN & ~WB_ACK_OUT;
    wire        hit_ctl = (WB_ADR_IN == REG_CTRL_ADDR);
    wire        hit_st  = (WB_ADR_IN == REG_STAT_ADDR);
    wire [31:0] status  = {24'h000000, so_en, SOFT_START_RELEASE_OUT,
                           forcing, de_mode, ext_sync, state};
    wire [31:0] rdata   = hit_ctl ? {24'h000000, ctrl} :
                          hit_st ? status : 32'h00000000;

    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            ctrl       <= CTRL_RESET;
            WB_ACK_OUT <= 1'b0;
            WB_DAT_OUT <= 32'h00000000;
        end else begin
            WB_ACK_OUT <= wb_req;
            if (wb_req && !WB_WE_IN) begin
                WB_DAT_OUT <= rdata;
            end
            if (wb_req && WB_WE_IN && hit_ctl && WB_SEL_IN[0]) begin
                ctrl <= WB_DAT_IN[7:0];
            end
        end
    end
endmodule

// ---- rtl/buck_seq_pkg.sv ----
// constants, types and field layout of the gate sequencer
// assumes a 10 MHz system clock and classic wishbone access
package buck_seq_pkg;

    // =========================================================
    // timing
    localparam int CLK_PERIOD_NS   = 100;
    localparam int BOOT_PULSE_NS   = 250;
    localparam int BOOT_PERIOD_NS  = 2000;
    localparam int FORCE_DELAY_NS  = 70;
    localparam int OSC_PERIOD_NS   = 500;
    localparam int BURST_PERIOD_NS = 2000;
    localparam logic [4:0] BOOT_PULSE_CYC  =
        5'((BOOT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [4:0] BOOT_PERIOD_CYC = 5'(BOOT_PERIOD_NS / CLK_PERIOD_NS);
    localparam logic [1:0] FORCE_DELAY_CYC =
        2'((FORCE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [4:0] OSC_PERIOD_CYC   = 5'(OSC_PERIOD_NS / CLK_PERIOD_NS);
    localparam logic [4:0] BURST_PERIOD_CYC = 5'(BURST_PERIOD_NS / CLK_PERIOD_NS);
    localparam logic [3:0] BOOT_PULSES      = 4'h8;
    localparam logic [1:0] BURST_PULSES     = 2'h3;
    localparam logic [4:0] SYNC_LOSS_CYC    = 5'(OSC_PERIOD_CYC + 5'h01);
    localparam logic [4:0] REASSERT_LOW_CYC  = 5'(OSC_PERIOD_CYC * 3);
    localparam logic [4:0] REASSERT_HIGH_CYC = 5'(OSC_PERIOD_CYC * 4);

    // =========================================================
    // filtered comparator inputs
    localparam int N_COMP       = 12;
    localparam int C_ENABLE     = 0;
    localparam int C_SW_HIGH    = 1;
    localparam int C_LSG_HIGH   = 2;
    localparam int C_ZERO_CUR   = 3;
    localparam int C_ERR_LOW    = 4;
    localparam int C_PWM_END    = 5;
    localparam int C_RAMP_OK    = 6;
    localparam int C_CUR_LIMIT  = 7;
    localparam int C_OUT_DROOP  = 8;
    localparam int C_INPUT_LOW_THRESHOLD    = 9;
    localparam int C_VIN_HIGH   = 10;
    localparam int C_FOLDBACK   = 11;

    // =========================================================
    // registers
    localparam int         WB_ADR_W      = 4;
    localparam logic [3:0] REG_CTRL_ADDR = 4'h0;
    localparam logic [3:0] REG_STAT_ADDR = 4'h4;
    localparam logic [7:0] CTRL_RESET    = 8'h43;
    localparam int CTRL_SKIP_EN  = 0;
    localparam int CTRL_FORCE_EN = 1;
    localparam int CTRL_MAXON_LO = 4;

    typedef enum logic [2:0] {
        ST_OFF      = 3'b000,
        ST_BOOT     = 3'b001,
        ST_RUN      = 3'b010,
        ST_REASSERT = 3'b011,
        ST_SKIP     = 3'b100,
        ST_BURST    = 3'b101
    } seq_state_type;

endpackage

// ---- rtl/comp_bus_if.sv ----
// filtered comparator levels between filter and sequencer
// assumes the package is compiled first
`timescale 1ns/10ps
interface comp_bus_if;
    logic [buck_seq_pkg::N_COMP-1:0] level;
    modport source (output level);
    modport sink   (input  level);
endinterface

// ---- rtl/comp_filter.sv ----
// two-flop synchroniser plus two-sample glitch filter per input
// assumes raw comparator levels asynchronous to clk_in
`timescale 1ns/10ps
module comp_filter (
    input  wire logic                            clk_in,
    input  wire logic                            rst_in,
    input  wire logic [buck_seq_pkg::N_COMP-1:0] raw_in,
    comp_bus_if.source                           bus
);
    import buck_seq_pkg::*;

    logic [N_COMP-1:0] meta;
    logic [N_COMP-1:0] stable;
    logic [N_COMP-1:0] prev;
    logic [N_COMP-1:0] level;

    genvar i;
    generate
        for (i = 0; i < N_COMP; i++) begin : g_ch
            always_ff @(posedge clk_in) begin
                if (rst_in) begin
                    meta[i]   <= 1'b0;
                    stable[i] <= 1'b0;
                    prev[i]   <= 1'b0;
                    level[i]  <= 1'b0;
                end else begin
                    meta[i]   <= raw_in[i];
                    stable[i] <= meta[i];
                    prev[i]   <= stable[i];
                    if (stable[i] == prev[i]) begin
                        level[i] <= stable[i];
                    end
                end
            end
        end
    endgenerate

    assign bus.level = level;
endmodule

// ---- rtl/osc_divider.sv ----
// period divider: one-cycle tick and square wave, stops when idle
// assumes period_in of at least two cycles
`timescale 1ns/10ps
module osc_divider (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       run_in,
    input  wire logic [4:0] period_in,
    output logic            tick_out,
    output logic            square_out
);
    logic [4:0] cnt;

    always_ff @(posedge clk_in) begin
        if (rst_in || !run_in) begin
            cnt        <= 5'h00;
            tick_out   <= 1'b0;
            square_out <= 1'b0;
        end else begin
            cnt        <= (cnt == period_in - 5'h01) ? 5'h00 : cnt + 5'h01;
            tick_out   <= (cnt == 5'h00);
            square_out <= (cnt < (period_in >> 1));
        end
    end
endmodule

// ---- testbench/buck_seq_monitor.sv ----
// checker for gate order, boot pulses, skip and sync output
// assumes bind onto the sequencer top, one clock domain
`timescale 1ns/10ps
module buck_seq_monitor (
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic ERROR_LOW_IN,
    input wire logic RAMP_OK_IN,
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_ACK_OUT,
    input wire logic HIGH_SIDE_GATE_OUT,
    input wire logic LOW_SIDE_GATE_OUT,
    input wire logic SYNC_OUT_OUT,
    input wire logic SOFT_START_RELEASE_OUT,
    input wire logic HYSTERETIC_MODE_OUT,
    input wire logic LOW_IQ_OUT
);
    // =========================================================
    // boot pulse counter and assertions
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    logic [3:0] boot_cnt;
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN || SOFT_START_RELEASE_OUT) begin
            boot_cnt <= 4'h0;
        end else if ($rose(LOW_SIDE_GATE_OUT)) begin
            boot_cnt <= boot_cnt + 4'h1;
        end
    end
    a_gate_no_overlap: assert property (!(HIGH_SIDE_GATE_OUT && LOW_SIDE_GATE_OUT))
        else $error("both gates on");
    a_high_after_low: assert property ($rose(HIGH_SIDE_GATE_OUT) |-> !$past(LOW_SIDE_GATE_OUT))
        else $error("high gate rose while low gate on");
    a_boot_width: assert property ($rose(LOW_SIDE_GATE_OUT) && !SOFT_START_RELEASE_OUT
        |-> LOW_SIDE_GATE_OUT[*3] ##1 !LOW_SIDE_GATE_OUT) else $error("boot pulse width");
    a_boot_count: assert property ($rose(SOFT_START_RELEASE_OUT) |-> boot_cnt == 4'h8)
        else $error("boot pulse count");
    a_sync_ramp_ok: assert property (SYNC_OUT_OUT |-> $past(RAMP_OK_IN, 2))
        else $error("sync output before ramp");
    a_sync_after_boot: assert property ($rose(SYNC_OUT_OUT) |-> SOFT_START_RELEASE_OUT)
        else $error("sync output before release");
    a_skip_sync_off: assert property (LOW_IQ_OUT && $past(LOW_IQ_OUT) |-> !SYNC_OUT_OUT)
        else $error("sync output active in skip");
    a_skip_from_error: assert property ($rose(LOW_IQ_OUT) |-> $past(ERROR_LOW_IN, 2))
        else $error("skip without error level");
    a_hyst_in_skip: assert property ($rose(HYSTERETIC_MODE_OUT)
        |-> LOW_IQ_OUT || $past(LOW_IQ_OUT)) else $error("hysteretic outside skip");
    a_bus_ack_pulse: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT
        |=> WB_ACK_OUT ##1 !WB_ACK_OUT) else $error("bus ack timing");
    c_boot_done: cover property ($rose(SOFT_START_RELEASE_OUT));
    c_skip_entry: cover property ($rose(LOW_IQ_OUT));
    c_hyst_entry: cover property ($rose(HYSTERETIC_MODE_OUT));
endmodule
bind buck_gate_sync_sequencer buck_seq_monitor i_mon (
    .CLK_IN, .SYS_RST_IN, .ERROR_LOW_IN, .RAMP_OK_IN, .WB_CYC_IN, .WB_STB_IN, .WB_ACK_OUT,
    .HIGH_SIDE_GATE_OUT, .LOW_SIDE_GATE_OUT, .SYNC_OUT_OUT, .SOFT_START_RELEASE_OUT,
    .HYSTERETIC_MODE_OUT, .LOW_IQ_OUT
);

// ---- testbench/fet_pair_model.sv ----
// model of the external switch pair and upstream sync source
// assumes gate commands high active; sync runs only when asked
`timescale 1ns/10ps
module fet_pair_model (
    input  wire logic hs_gate_in,
    input  wire logic ls_gate_in,
    input  wire logic sync_run_in,
    output logic      sw_high_out,
    output logic      ls_gate_high_out,
    output logic      sync_out
);
    // =========================================================
    // switch node, gate level and 800 ns sync clock
    assign #40 sw_high_out = hs_gate_in;
    assign #30 ls_gate_high_out = ls_gate_in;
    initial sync_out = 1'b0;
    always #400 sync_out = sync_run_in & ~sync_out;
endmodule

// ---- testbench/buck_gate_sync_sequencer_tb.sv ----
// self-checking bench of the gate sequencer
// assumes the package, design files and checker compiled first
`timescale 1ns/10ps
module buck_gate_sync_sequencer_tb;
    import buck_seq_pkg::*;
    logic        clk, rst, en, err_low, ramp_ok, input_low_threshold, fold, sync_run;
    logic        cyc, stb, we, hs, ls, sync_o, ssr, sink, hyst, low_iq, wb_ack, sw_high;
    logic        lsg_high, sync_in;
    logic [3:0]  adr, sel;
    logic [31:0] wdat, wb_q, q;
    int          error_cnt, cmp_count;
    fet_pair_model i_fet (.hs_gate_in(hs), .ls_gate_in(ls), .sync_run_in(sync_run),
        .sw_high_out(sw_high), .ls_gate_high_out(lsg_high), .sync_out(sync_in));
    buck_gate_sync_sequencer i_dut (.CLK_IN(clk), .SYS_RST_IN(rst), .SYNC_IN_IN(sync_in),
        .ENABLE_IN(en), .SW_HIGH_IN(sw_high), .LS_GATE_HIGH_IN(lsg_high),
        .ZERO_CURRENT_IN(1'b0), .ERROR_LOW_IN(err_low), .PWM_END_IN(1'b0),
        .RAMP_OK_IN(ramp_ok), .CURRENT_LIMIT_IN(1'b0), .OUTPUT_DROOP_IN(1'b0),
        .INPUT_LOW_THRESHOLD_IN(input_low_threshold), .VIN_HIGH_IN(1'b0), .FOLDBACK_IN(fold), .WB_CYC_IN(cyc),
        .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_DAT_IN(wdat), .WB_SEL_IN(sel),
        .WB_DAT_OUT(wb_q), .WB_ACK_OUT(wb_ack), .HIGH_SIDE_GATE_OUT(hs),
        .LOW_SIDE_GATE_OUT(ls), .SYNC_OUT_OUT(sync_o), .SOFT_START_RELEASE_OUT(ssr),
        .SINK_ENABLE_OUT(sink), .HYSTERETIC_MODE_OUT(hyst), .LOW_IQ_OUT(low_iq));
    always #50 clk = ~clk;
    // =========================================================
    // shared tasks
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic guard(inout int n, input int lim);
        n++;
        if (n > lim) begin
            error_cnt++;
            $display("[ERR] wait expected done seen timeout");
            end_of_test();
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            guard(n, 20);
        end while (wb_ack !== 1'b1);
        q = wb_q;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic pulses(inout int c, inout int p, input logic s, inout logic pv);
        p++;
        if (s === 1'b1 && pv !== 1'b1) c++;
        pv = s;
    endtask
    // =========================================================
    // scenarios
    task automatic t_regs;
        chk("idle outputs", 32'h0, {hs, ls, sync_o, ssr, sink, hyst, low_iq});
        wb(1'b0, REG_CTRL_ADDR, 32'h0);
        chk("ctrl reset", 32'(CTRL_RESET), q);
        wb(1'b1, REG_CTRL_ADDR, 32'h61);
        sel <= 4'h0;
        wb(1'b1, REG_CTRL_ADDR, 32'hFF);
        sel <= 4'hF;
        wb(1'b0, REG_CTRL_ADDR, 32'h0);
        chk("ctrl readback", 32'h61, q);
        wb(1'b1, REG_STAT_ADDR, 32'hFF);
        wb(1'b0, REG_STAT_ADDR, 32'h0);
        chk("status off", 32'h0, q & 32'h7);
        wb(1'b0, 4'h8, 32'h0);
        chk("unmapped read", 32'h0, q);
        $display("register test end");
    endtask
    task automatic t_boot;
        int n, w, p, c;
        logic pv;
        n = 0; w = 0; p = 0; c = 0; pv = 1'b0;
        en <= 1'b1;
        while (ssr !== 1'b1) begin
            @(posedge clk);
            guard(n, 400);
            if (ssr === 1'b1) break;
            if (ls === 1'b1 && pv !== 1'b1 && c > 0) chk("boot period", 32'(BOOT_PERIOD_CYC), p);
            if (ls !== 1'b1 && pv === 1'b1) chk("boot width", 32'(BOOT_PULSE_CYC), w);
            if (ls !== 1'b1) w = 0;
            else w++;
            if (ls === 1'b1 && pv !== 1'b1) p = 0;
            pulses(c, p, ls, pv);
        end
        chk("boot pulses", 32'(BOOT_PULSES), c);
        ramp_ok <= 1'b1;
        $display("boot test end");
    endtask
    task automatic t_run;
        int n, p, c;
        logic pv;
        n = 0; p = 0; c = 0; pv = 1'b0;
        repeat (60) @(posedge clk) pulses(c, p, hs, pv);
        chk("osc pulses", 32'h1, 32'(c >= 2));
        wb(1'b0, REG_STAT_ADDR, 32'h0);
        chk("diode mode", 32'h10, q & 32'h18);
        input_low_threshold <= 1'b1;
        repeat (10) @(posedge clk);
        chk("sink input_low_threshold", 32'h1, 32'(sink));
        input_low_threshold <= 1'b0;
        fold <= 1'b1;
        repeat (10) @(posedge clk);
        chk("sink foldback", 32'h1, 32'(sink));
        fold <= 1'b0;
        repeat (10) @(posedge clk);
        chk("sink off", 32'h0, 32'(sink));
        $display("run test end");
    endtask
    task automatic t_skip;
        int n, p, c;
        logic pv;
        n = 0; p = 0; c = 0; pv = 1'b0;
        err_low <= 1'b1;
        while (low_iq !== 1'b1) @(posedge clk) guard(n, 100);
        repeat (3) @(posedge clk);
        chk("skip sync out", 32'h0, 32'(sync_o));
        chk("hysteretic", 32'h1, 32'(hyst));
        err_low <= 1'b0;
        while (low_iq !== 1'b0) @(posedge clk) guard(n, 200);
        while (c < 2) begin
            @(posedge clk);
            guard(n, 400);
            if (hs === 1'b1 && pv !== 1'b1 && c == 1) chk("burst period", 32'(BURST_PERIOD_CYC), p);
            if (hs === 1'b1 && pv !== 1'b1) p = 0;
            pulses(c, p, hs, pv);
        end
        $display("skip test end");
    endtask
    task automatic t_sync;
        int n;
        n = 0;
        sync_run <= 1'b1;
        repeat (40) @(posedge clk);
        chk("sink ext clock", 32'h1, 32'(sink));
        do begin
            wb(1'b0, REG_STAT_ADDR, 32'h0);
            guard(n, 30);
        end while (q[2:0] !== 3'h3);
        chk("reassert gates", 32'h1, {hs, ls});
        sync_run <= 1'b0;
        repeat (30) @(posedge clk);
        wb(1'b0, REG_STAT_ADDR, 32'h0);
        chk("osc regained", 32'h2, q & 32'hF);
        $display("sync test end");
    endtask
    initial begin
        int n;
        clk = 1'b0; rst = 1'b1; en = 1'b0; err_low = 1'b0; ramp_ok = 1'b0; input_low_threshold = 1'b0;
        fold = 1'b0; sync_run = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 4'h0;
        wdat = 32'h0; error_cnt = 0; cmp_count = 0; n = 0; sel = 4'hF;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_boot();
        t_run();
        t_skip();
        t_sync();
        en <= 1'b0;
        while (ssr !== 1'b0) @(posedge clk) guard(n, 100);
        t_boot();
        end_of_test();
    end
endmodule
